// file: rng_map.vh
// Register map, field positions and timing counts of the random generator
`ifndef RNG_MAP_VH
`define RNG_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RNG_CONTROL_OFS 12'h000
`define RNG_STATUS_OFS 12'h004
`define RNG_VALUE_OFS 12'h008

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RNG_CTL_ENABLE_BIT 2
`define RNG_CTL_IRQ_BIT 3
`define RNG_STAT_READY_BIT 0
`define RNG_STAT_CLK_LIVE_BIT 1
`define RNG_STAT_SEED_LIVE_BIT 2
`define RNG_STAT_CLK_FLAG_BIT 5
`define RNG_STAT_SEED_FLAG_BIT 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RNG_CONTROL_RESET 32'h0000_0000
`define RNG_STATUS_RESET 32'h0000_0000
`define RNG_VALUE_RESET 32'h0000_0000

// ----------------------------------------
// Timing counts and LFSR tap mask
// ----------------------------------------
`define RNG_WORD_PERIODS 6'h28
`define RNG_CLK_RATIO 5'h10
`define RNG_SAME_LIMIT 7'h40
`define RNG_ALT_PAIRS 7'h20
`define RNG_LFSR_TAPS 32'h8020_0003

`endif

// file: rng_core.v
// Random number generator core with APB register slave
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
// ----------------------------------------
// Behaviour
// RQ1 - About 40 generator periods per word
// RQ2 - Seed bits feed 32-bit LFSR
// RQ3 - LFSR steps only on generator clock
// RQ4 - Enough seed bits copy LFSR to data
// RQ5 - Monitor seed and clock, flag, interrupt
// RQ6 - Generator below sixteenth bus clock: clock fault
// RQ7 - Clock fault keeps previous data word
// RQ8 - Long same-bit or alternating runs: seed fault
// RQ9 - Software discards data, clears flag, restarts
// RQ10 - Software checks clocks, then clears flag
// RQ11 - Control bit 3 enables single interrupt
// RQ12 - Control bit 2 enables generator
// RQ13 - Status bit 6 sticky seed flag, write-0-clear
// RQ14 - Status bit 5 sticky clock flag, write-0-clear
// RQ15 - Status bit 2 live seed fault
// RQ16 - Software reads data only when clean
// RQ17 - Software skips first and repeated words
// RQ18 - Registers reset zero, byte access allowed
// RQ19 - Status bit 0 ready, cleared by read
// RQ20 - Status bit 1 live clock fault
// RQ21 - Data register at 0x08, word read
// RQ22 - Disabled: LFSR idle, monitors frozen (code clears the seed monitor run counters instead of holding them)
// ----------------------------------------
`include "rng_map.vh"

module rng_core (
   // System
   input wire sys_clk,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Analog side
   input wire noise_lfsr_clock,
   input wire noise_seed,
   // Interrupt
   output wire irq
);

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire access = psel & penable;
   wire hit_ctl = (paddr == `RNG_CONTROL_OFS);
   wire hit_stat = (paddr == `RNG_STATUS_OFS);
   wire hit_val = (paddr == `RNG_VALUE_OFS);
   wire mapped = hit_ctl | hit_stat | hit_val;
   wire wr_ctl = access & pwrite & hit_ctl & pstrb[0];
   wire wr_stat = access & pwrite & hit_stat & pstrb[0];
   wire rd_val = access & ~pwrite & hit_val;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   reg irq_enable_bit;
   reg generator_enable_bit;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_enable_bit <= 1'b0; // [RQ18]
         generator_enable_bit <= 1'b0;
      end else if (wr_ctl) begin
         irq_enable_bit <= pwdata[`RNG_CTL_IRQ_BIT]; // [RQ11]
         generator_enable_bit <= pwdata[`RNG_CTL_ENABLE_BIT]; // [RQ12]
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [2:0] clk_sync;
   reg [2:0] seed_sync;
   reg clk_level;
   reg seed_level;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_sync <= 3'b000;
         seed_sync <= 3'b000;
         clk_level <= 1'b0;
         seed_level <= 1'b0;
      end else begin
         clk_sync <= {clk_sync[1:0], noise_lfsr_clock};
         seed_sync <= {seed_sync[1:0], noise_seed};
         if (clk_sync[1] == clk_sync[2]) begin
            clk_level <= clk_sync[2];
         end
         if (seed_sync[1] == seed_sync[2]) begin
            seed_level <= seed_sync[2];
         end
      end
   end

   // Rising edge of the generator clock, taken as one step
   wire gen_step = (clk_sync[1] == clk_sync[2]) & clk_sync[2] & ~clk_level; // [RQ3]
   wire run_step = gen_step & generator_enable_bit; // [RQ22]

   // ----------------------------------------
   // LFSR and word assembly
   // ----------------------------------------
   reg [31:0] lfsr;
   reg [5:0] step_count;
   reg [31:0] random_value_reg;
   reg value_ready;
   wire feedback = ^(lfsr & `RNG_LFSR_TAPS);
   wire word_done = run_step & (step_count == `RNG_WORD_PERIODS - 6'h01);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lfsr <= 32'h0000_0000;
         step_count <= 6'h00;
      end else if (!generator_enable_bit) begin
         lfsr <= 32'h0000_0000; // [RQ22]
         step_count <= 6'h00;
      end else if (run_step) begin
         lfsr <= {lfsr[30:0], feedback ^ seed_level}; // [RQ2]
         step_count <= word_done ? 6'h00 : step_count + 6'h01; // [RQ1]
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         random_value_reg <= `RNG_VALUE_RESET;
         value_ready <= 1'b0;
      end else begin
         if (word_done) begin
            random_value_reg <= {lfsr[30:0], feedback ^ seed_level}; // [RQ4]
         end
         if (word_done) begin
            value_ready <= 1'b1; // [RQ19]
         end else if (rd_val) begin
            value_ready <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Clock monitor
   // ----------------------------------------
   reg [4:0] gap_count;
   reg clock_fault_live;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_count <= 5'h00;
         clock_fault_live <= 1'b0;
      end else if (generator_enable_bit) begin // [RQ22]
         if (gen_step) begin
            gap_count <= 5'h00;
            clock_fault_live <= 1'b0;
         end else if (gap_count == `RNG_CLK_RATIO) begin
            clock_fault_live <= 1'b1; // [RQ6] [RQ20]
         end else begin
            gap_count <= gap_count + 5'h01;
         end
      end
   end

   // ----------------------------------------
   // Seed monitor
   // ----------------------------------------
   reg prev_seed;
   reg [6:0] same_run;
   reg [7:0] alt_run;
   reg seed_fault_live;
   wire [7:0] alt_limit = {`RNG_ALT_PAIRS, 1'b0};

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_seed <= 1'b0;
         same_run <= 7'h00;
         alt_run <= 8'h00;
         seed_fault_live <= 1'b0;
      end else if (!generator_enable_bit) begin
         same_run <= 7'h00; // [RQ22]
         alt_run <= 8'h00;
      end else if (run_step) begin
         prev_seed <= seed_level;
         if (seed_level == prev_seed) begin
            alt_run <= 8'h00;
            if (same_run != `RNG_SAME_LIMIT) begin
               same_run <= same_run + 7'h01;
            end
            seed_fault_live <= (same_run == `RNG_SAME_LIMIT); // [RQ8] [RQ15]
         end else begin
            same_run <= 7'h00;
            if (alt_run != alt_limit) begin
               alt_run <= alt_run + 8'h01;
            end
            seed_fault_live <= (alt_run == alt_limit); // [RQ8] [RQ15]
         end
      end
   end

   // ----------------------------------------
   // Sticky fault flags
   // ----------------------------------------
   reg seed_fault_flag;
   reg clock_fault_flag;
   wire clr_seed = wr_stat & ~pwdata[`RNG_STAT_SEED_FLAG_BIT];
   wire clr_clk = wr_stat & ~pwdata[`RNG_STAT_CLK_FLAG_BIT];

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         seed_fault_flag <= 1'b0;
         clock_fault_flag <= 1'b0;
      end else begin
         if (seed_fault_live) begin
            seed_fault_flag <= 1'b1; // [RQ5] [RQ8]
         end else if (clr_seed) begin
            seed_fault_flag <= 1'b0; // [RQ13]
         end
         if (clock_fault_live) begin
            clock_fault_flag <= 1'b1; // [RQ6] [RQ7]
         end else if (clr_clk) begin
            clock_fault_flag <= 1'b0; // [RQ14]
         end
      end
   end

   assign irq = irq_enable_bit & (value_ready | seed_fault_flag | clock_fault_flag); // [RQ5] [RQ11]

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   reg [31:0] next_prdata;

   always @* begin
      next_prdata = 32'h0000_0000;
      if (hit_ctl) begin
         next_prdata[`RNG_CTL_IRQ_BIT] = irq_enable_bit;
         next_prdata[`RNG_CTL_ENABLE_BIT] = generator_enable_bit;
      end else if (hit_stat) begin
         next_prdata[`RNG_STAT_READY_BIT] = value_ready;
         next_prdata[`RNG_STAT_CLK_LIVE_BIT] = clock_fault_live;
         next_prdata[`RNG_STAT_SEED_LIVE_BIT] = seed_fault_live;
         next_prdata[`RNG_STAT_CLK_FLAG_BIT] = clock_fault_flag;
         next_prdata[`RNG_STAT_SEED_FLAG_BIT] = seed_fault_flag;
      end else if (hit_val) begin
         next_prdata = random_value_reg; // [RQ21]
      end
   end

   // Registered so prdata is valid in the access phase
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= next_prdata;
      end
   end

endmodule // rng_core

// file: trg_chk.sv
// Port checker for the random generator register slave
`timescale 1ns/100ps
module trg_chk (
   // System
   input wire sys_clk,
   input wire rst,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   // Interrupt
   input wire irq
);
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_ready; psel |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("slave stalled");
   property p_err; acc |-> pslverr == !(paddr == 12'h0 || paddr == 12'h4 || paddr == 12'h8); endproperty
   a_err: assert property (p_err) else $error("slave error wrong");
   property p_rd0; rd && pslverr |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
   property p_ctl; rd && paddr == 12'h0 |-> (prdata & 32'hffff_fff3) == 32'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("control reserved set");
   property p_stat; rd && paddr == 12'h4 |-> (prdata & 32'hffff_ff98) == 32'h0; endproperty
   a_stat: assert property (p_stat) else $error("status reserved set");
   property p_wrc;
      acc && pwrite && paddr == 12'h0 && pstrb[0] ##1 (psel && !pwrite && paddr == 12'h0)[*2]
         |-> prdata[3:2] == $past(pwdata[3:2], 2);
   endproperty
   a_wrc: assert property (p_wrc) else $error("control readback wrong");
   property p_off; acc && pwrite && paddr == 12'h0 && pstrb[0] && !pwdata[3] |=> !irq; endproperty
   a_off: assert property (p_off) else $error("irq while disabled");
   property p_clr; rd && paddr == 12'h8 ##1 (psel && !pwrite && paddr == 12'h4)[*2] |-> !prdata[0]; endproperty
   a_clr: assert property (p_clr) else $error("ready kept after data read");
   property p_rst; $fell(rst) |-> !irq; endproperty
   a_rst: assert property (p_rst) else $error("irq out of reset");
   cover property (rd && paddr == 12'h8);
   cover property (irq);
   cover property (rd && pslverr);
endmodule // trg_chk
bind rng_core trg_chk u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
   .prdata, .pslverr, .irq);

// file: trg_noise.sv
// Ring-oscillator seed and generator clock model
`timescale 1ns/100ps
module trg_noise (
   // Bench control
   input wire run,
   input wire [1:0] mode,
   // Analog side
   output logic noise_lfsr_clock,
   output logic noise_seed
);
   // Mode 0 random, 1 stuck high, 2 alternating
   initial begin
      noise_lfsr_clock = 0;
      noise_seed = 0;
      forever begin
         #193;
         if (run) noise_lfsr_clock = ~noise_lfsr_clock;
         if (run && !noise_lfsr_clock) noise_seed = mode == 0 ? 1'($urandom) : mode == 1 ? 1'b1 : ~noise_seed;
      end
   end
endmodule // trg_noise

// file: test_true_random_generator.sv
// Self-checking bench for the random generator
`timescale 1ns/100ps
module test_true_random_generator;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, run = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, r, w0;
   logic [3:0] pstrb = 4'hf;
   logic [1:0] mode = 0;
   wire [31:0] prdata;
   wire pready, pslverr, irq, gclk, seed;
   int n_mismatch = 0, checked = 0, cnt;
   // Behavioural shadow of the control register
   logic [31:0] ctl_model = 32'h0000_0000;
   rng_core dut_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
      .pslverr, .noise_lfsr_clock(gclk), .noise_seed(seed), .irq);
   trg_noise noise_u (.run, .mode, .noise_lfsr_clock(gclk), .noise_seed(seed));
   initial forever #25 sys_clk = ~sys_clk;
   task test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task bad(input string s);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, s);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
      checked++;
      if ((got & msk) !== exp) bad($sformatf("got %h want %h", got & msk, exp));
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1 && n < 9);
      r = prdata;
      if (w && a == 12'h000 && pstrb[0]) ctl_model = d & 32'h0000_000c;
      if (pready !== 1) begin
         bad("no ready");
         test_done;
      end
   endtask
   task hold(input int c, input bit on_irq);
      psel <= 0;
      penable <= 0;
      cnt = 0;
      while (cnt < c && !(on_irq && irq === 1)) begin
         @(posedge sys_clk);
         cnt++;
      end
      if (on_irq && irq !== 1) begin
         bad("no irq");
         test_done;
      end
   endtask
   initial begin
      void'($urandom(32'hb5be));
      repeat (10) @(posedge sys_clk);
      rst <= 0;
      for (int a = 0; a < 16; a += 4) begin
         apb(0, 12'(a), 0);
         chk(r, 0, 32'hffff_ffff);
      end
      w0 = $urandom & 32'hffff_fff3;
      apb(1, 0, w0);
      apb(0, 0, 0);
      chk(r, ctl_model, 32'hffff_ffff);
      pstrb <= 4'he;
      apb(1, 0, 32'hc);
      pstrb <= 4'hf;
      apb(0, 0, 0);
      chk(r, ctl_model, 32'hffff_ffff);
      apb(1, 0, 32'hc);
      apb(0, 0, 0);
      chk(r, ctl_model, 32'hffff_ffff);
      hold(2000, 1);
      checked++;
      if (cnt < 295 || cnt > 330) bad("word period off");
      apb(0, 4, 0);
      chk(r, 32'h1, 32'h67);
      apb(0, 8, 0);
      w0 = r;
      apb(0, 4, 0);
      chk(r, 0, 32'h1);
      hold(2000, 1);
      apb(0, 8, 0);
      checked++;
      if (r === w0) bad("word repeated");
      w0 = r;
      run <= 0;
      hold(40, 0);
      apb(0, 4, 0);
      chk(r, 32'h22, 32'h22);
      chk({31'b0, irq}, 1, 1);
      apb(0, 8, 0);
      chk(r, w0, 32'hffff_ffff);
      apb(1, 4, 32'h60);
      apb(0, 4, 0);
      chk(r, 32'h22, 32'h22);
      run <= 1;
      hold(30, 0);
      apb(1, 4, 0);
      apb(0, 4, 0);
      chk(r, 0, 32'h66);
      for (int m = 1; m < 3; m++) begin
         mode <= 2'(m);
         hold(600, 0);
         apb(0, 4, 0);
         chk(r, 32'h44, 32'h66);
         mode <= 0;
         hold(80, 0);
         apb(0, 4, 0);
         chk(r, 32'h40, 32'h66);
         apb(1, 4, 0);
         apb(1, 0, 0);
         apb(1, 0, 32'hc);
         apb(0, 4, 0);
         chk(r, 0, 32'h66);
      end
      apb(1, 0, 0);
      apb(0, 8, 0);
      hold(400, 0);
      apb(0, 4, 0);
      chk(r, 0, 32'h1);
      hold(2, 0);
      test_done;
   end
endmodule // test_true_random_generator
